// ===== verification/lic_line_model.sv
// Line side model: recovered clock and received bit patterns
`timescale 1ns/1ns
module lic_line_model (
	// Pattern select: 0 ones, 1 zeros, 2 loop-up, 3 loop-down
	input wire logic [1:0] i_pat,
	// Recovered clock and bit
	output logic o_rclk,
	output logic o_rx_bit
);
	// Phase counter, 15 covers both the 5 and 3 bit periods
	int k = 0;
	// Recovered clock runs free, 80 ns period
	initial
	begin
		o_rclk = 1'h0;
		forever #40 o_rclk = ~o_rclk;
	end
	// Bits change on the falling edge so they are stable at each rise
	always @(negedge o_rclk)
	begin
		k <= (k == 14) ? 0 : k + 1;
		case (i_pat)
			2'h0: o_rx_bit <= 1'h1;
			2'h1: o_rx_bit <= 1'h0;
			2'h2: o_rx_bit <= (k % 5 == 4);
			default: o_rx_bit <= (k % 3 == 2);
		endcase
	end
	initial o_rx_bit = 1'h1;
endmodule

// ===== verification/lic_top_test.sv
// Self-checking bench for the line interface control block
`timescale 1ns/1ns
module lic_top_test;
	import lic_pkg::*;
	// ==========================================================
	// Signals
	logic I_CLK_SYS, I_NRST, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK;
	logic [7:0] I_WB_ADR;
	logic [31:0] I_WB_DAT, O_WB_DAT, rd;
	logic [3:0] I_WB_SEL;
	logic I_MODE_SEL, I_MCLK, I_OSC_REF_IN, I_UNIPOLAR, I_E1_SEL;
	logic I_SEND_ALL_MARKS_SEL, I_NEAR_END_LOOPBACK_SEL;
	logic I_FAR_END_LOOPBACK_SEL, I_DEJITTER_PATH_SEL;
	logic [1:0] I_TX_PULSE_BUILDOUT_SEL, I_EQ_GAIN, O_TX_PULSE_BUILDOUT, pat;
	logic I_RCLK, I_RX_BIT, I_ALL_ONES_ALARM, I_SCLK, I_SERIAL_IN;
	logic I_OUTPUT_EDGE_SEL, O_SERIAL_OUT, O_HOST_MODE, O_B8ZS_EN;
	logic O_REF_FROM_MCLK, O_DEJITTER_EN, O_DEJITTER_IN_RX, O_TX_ALL_MARKS;
	logic O_NEAR_LOOP_LINE, O_NEAR_LOOP_DEJITTER, O_FAR_LOOP, O_CODEC_BYPASS;
	logic O_LOOP_DETECT_EN, O_CAL_RESTART, O_SIGNAL_ABSENT_FLAG, mclk_on;
	logic O_INBAND_LOOP_STATE, O_RX_GAIN_CODE_OUT, O_ALERT_N_O, O_ALERT_N_OE;
	lic_rclk_src_t O_RCLK_SRC;
	int fails = 0, checks_done = 0, cyc_n = 0;
	// Short counts keep the loop code run brief
	lic_top #(.QUAL_BITS_T1(40), .QUAL_BITS_E1(40), .TOGGLE_WIN(64)) dut_u (
		.I_CLK_SYS, .I_NRST, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR,
		.I_WB_DAT, .I_WB_SEL, .O_WB_DAT, .O_WB_ACK, .I_MODE_SEL, .I_MCLK,
		.I_OSC_REF_IN, .I_UNIPOLAR, .I_E1_SEL, .I_SEND_ALL_MARKS_SEL,
		.I_NEAR_END_LOOPBACK_SEL, .I_FAR_END_LOOPBACK_SEL,
		.I_DEJITTER_PATH_SEL, .I_TX_PULSE_BUILDOUT_SEL, .I_RCLK, .I_RX_BIT,
		.I_EQ_GAIN, .I_ALL_ONES_ALARM, .I_SCLK, .I_SERIAL_IN,
		.I_OUTPUT_EDGE_SEL, .O_SERIAL_OUT, .O_HOST_MODE, .O_B8ZS_EN,
		.O_REF_FROM_MCLK, .O_DEJITTER_EN, .O_DEJITTER_IN_RX,
		.O_TX_PULSE_BUILDOUT, .O_TX_ALL_MARKS, .O_NEAR_LOOP_LINE,
		.O_NEAR_LOOP_DEJITTER, .O_FAR_LOOP, .O_CODEC_BYPASS,
		.O_LOOP_DETECT_EN, .O_CAL_RESTART, .O_SIGNAL_ABSENT_FLAG,
		.O_RCLK_SRC, .O_INBAND_LOOP_STATE, .O_RX_GAIN_CODE_OUT,
		.O_ALERT_N_O, .O_ALERT_N_OE);
	lic_line_model line_u (.i_pat(pat), .o_rclk(I_RCLK), .o_rx_bit(I_RX_BIT));
	// ==========================================================
	// Clocks and timeout
	initial
	begin
		I_CLK_SYS = 1'h0;
		forever #5 I_CLK_SYS = ~I_CLK_SYS;
	end
	// Master clock of 160 ns period; the timeout guards every wait
	always @(posedge I_CLK_SYS)
	begin
		cyc_n <= cyc_n + 1;
		if (mclk_on && cyc_n % 8 == 0)
			I_MCLK <= ~I_MCLK;
		if (cyc_n == 40000)
		begin
			fails = fails + 1;
			finish_test();
		end
	end
	// ==========================================================
	// Shared tasks
	task finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Case equality so an unknown never passes
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge I_CLK_SYS);
	endtask
	task rw(input int n);
		repeat (n) @(posedge I_RCLK);
	endtask
	// Classic cycle: hold until ack is sampled, then release
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK_SYS);
		{I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT, I_WB_SEL} <=
			{2'h3, we, a, d, 4'hf};
		// The ack ends this wait; without one, only the bench timeout does
		do
		begin
			@(posedge I_CLK_SYS);
		end
		while (O_WB_ACK !== 1'h1);
		rd = O_WB_DAT;
		chk(O_WB_ACK, 32'h1);
		{I_WB_CYC, I_WB_STB} <= 2'h0;
	endtask
	// Hardware pins in marks, near, far order
	task pins(input logic [2:0] s);
		@(posedge I_CLK_SYS);
		I_SEND_ALL_MARKS_SEL <= s[2];
		I_NEAR_END_LOOPBACK_SEL <= s[1];
		I_FAR_END_LOOPBACK_SEL <= s[0];
		cyc(8);
	endtask
	// ==========================================================
	// Scenarios
	task t_decode();
		logic [2:0] c [6] = '{3'h4, 3'h5, 3'h6, 3'h2, 3'h1, 3'h7};
		logic [5:0] e [6] = '{6'h20, 6'h06, 6'h28, 6'h10, 6'h06, 6'h21};
		for (int i = 0; i < 6; i++)
		begin
			pins(c[i]);
			chk({O_TX_ALL_MARKS, O_NEAR_LOOP_LINE, O_NEAR_LOOP_DEJITTER,
				O_FAR_LOOP, O_CODEC_BYPASS, O_LOOP_DETECT_EN}, e[i]);
		end
	endtask
	task t_config();
		for (int c = 0; c < 4; c++)
		begin
			@(posedge I_CLK_SYS);
			I_TX_PULSE_BUILDOUT_SEL <= c[1:0];
			cyc(8);
			chk(O_TX_PULSE_BUILDOUT, c);
		end
		chk(O_REF_FROM_MCLK, 32'h1);
		chk(O_DEJITTER_EN, 32'h1);
		I_DEJITTER_PATH_SEL <= 1'h1;
		cyc(8);
		chk(O_DEJITTER_IN_RX, 32'h1);
	endtask
	// Loop codes need all three pins, left high by the decode table
	task t_inband();
		pat <= 2'h2;
		rw(30);
		chk(O_INBAND_LOOP_STATE, 32'h0);
		for (int i = 0; i < 100 && O_INBAND_LOOP_STATE !== 1'h1; i++)
			rw(1);
		chk({O_INBAND_LOOP_STATE, O_FAR_LOOP}, 32'h3);
		pat <= 2'h3;
		rw(30);
		chk(O_INBAND_LOOP_STATE, 32'h1);
		for (int i = 0; i < 100 && O_INBAND_LOOP_STATE !== 1'h0; i++)
			rw(1);
		chk(O_INBAND_LOOP_STATE, 32'h0);
	endtask
	task t_hwreset();
		logic seen;
		seen = 1'h0;
		pins(3'h0);
		pins(3'h3);
		for (int i = 0; i < 60; i++)
		begin
			@(posedge I_CLK_SYS);
			seen = seen | (O_CAL_RESTART === 1'h1);
		end
		chk({seen, O_NEAR_LOOP_LINE, O_FAR_LOOP}, 32'h4);
		pins(3'h0);
	endtask
	task t_host();
		I_MODE_SEL <= 1'h1;
		// A fresh edge looks like a clock until the activity window ends
		cyc(80);
		chk(O_HOST_MODE, 32'h1);
		wb(1'h1, ADR_CTRL, 32'h31);
		wb(1'h0, ADR_CTRL, 32'h0);
		chk(rd, 32'h31);
		cyc(8);
		chk({O_TX_ALL_MARKS, O_TX_PULSE_BUILDOUT}, 32'h7);
		wb(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		wb(1'h1, ADR_CTRL, 32'h06);
		cyc(4);
		wb(1'h0, ADR_CTRL, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, ADR_STAT, 32'h0);
		chk(rd[3], 32'h1);
	endtask
	task t_los();
		pat <= 2'h1;
		rw(170);
		chk(O_SIGNAL_ABSENT_FLAG, 32'h0);
		rw(10);
		chk(O_SIGNAL_ABSENT_FLAG, 32'h1);
		chk(O_RCLK_SRC, SRC_MCLK);
		chk({O_ALERT_N_OE, O_ALERT_N_O}, 32'h2);
		wb(1'h0, ADR_STAT, 32'h0);
		chk(rd & 32'h81, 32'h81);
		cyc(4);
		chk(O_ALERT_N_OE, 32'h0);
		wb(1'h1, ADR_CTRL, 32'h08);
		cyc(8);
		chk(O_RCLK_SRC, SRC_MCLK);
		mclk_on <= 1'h0;
		wb(1'h1, ADR_CTRL, 32'h0);
		cyc(120);
		chk({O_REF_FROM_MCLK, O_RCLK_SRC}, {1'h0, SRC_OSC});
		mclk_on <= 1'h1;
		pat <= 2'h0;
		rw(100);
		chk(O_SIGNAL_ABSENT_FLAG, 32'h1);
		rw(100);
		chk(O_SIGNAL_ABSENT_FLAG, 32'h0);
	endtask
	// Second byte out carries the alarm; edge select low, so read at fall
	task t_serial();
		logic [15:0] v;
		logic [15:0] so;
		v = 16'h5aa5;
		so = 16'h0000;
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge I_CLK_SYS);
			I_ALL_ONES_ALARM <= 1'h1;
			I_SERIAL_IN <= v[i];
			cyc(4);
			I_SCLK <= 1'h1;
			cyc(4);
			so = {so[14:0], O_SERIAL_OUT};
			I_SCLK <= 1'h0;
		end
		chk(so, 32'h0002);
		cyc(8);
		wb(1'h0, ADR_SER, 32'h0);
		chk(rd, 32'ha5);
	endtask
	// Highs are counted at rclk rises over two whole frames
	task t_gain();
		logic [31:0] n;
		for (int c = 0; c < 4; c++)
		begin
			@(posedge I_CLK_SYS);
			I_EQ_GAIN <= c[1:0];
			rw(10);
			n = 32'h0;
			for (int i = 0; i < 10; i++)
			begin
				@(posedge I_RCLK);
				n = n + O_RX_GAIN_CODE_OUT;
			end
			chk(n, (c == 0) ? 8 : 2 * c);
			wb(1'h0, ADR_GAIN, 32'h0);
			chk(rd, c);
		end
	endtask
	// Mode pin toggling like a clock, unipolar format on
	task t_b8zs();
		I_UNIPOLAR <= 1'h1;
		repeat (40)
		begin
			cyc(4);
			I_MODE_SEL <= ~I_MODE_SEL;
		end
		chk({O_B8ZS_EN, O_HOST_MODE}, 32'h2);
	endtask
	// ==========================================================
	// Main sequence; three strap inputs stay tied low
	initial
	begin
		{I_NRST, I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT} = '0;
		{I_MODE_SEL, I_MCLK, I_OSC_REF_IN, I_UNIPOLAR, I_E1_SEL} = '0;
		{I_SEND_ALL_MARKS_SEL, I_NEAR_END_LOOPBACK_SEL} = '0;
		{I_FAR_END_LOOPBACK_SEL, I_DEJITTER_PATH_SEL} = '0;
		{I_TX_PULSE_BUILDOUT_SEL, I_EQ_GAIN, I_ALL_ONES_ALARM} = '0;
		{I_SCLK, I_SERIAL_IN, I_OUTPUT_EDGE_SEL, pat, mclk_on} = '0;
		I_WB_SEL = 4'hf;
		cyc(20);
		I_NRST <= 1'h1;
		chk({O_SIGNAL_ABSENT_FLAG, O_RCLK_SRC, O_WB_ACK}, 32'h0);
		mclk_on <= 1'h1;
		cyc(120);
		t_decode();
		t_config();
		t_inband();
		t_hwreset();
		t_host();
		t_los();
		t_serial();
		t_gain();
		t_b8zs();
		finish_test();
	end
endmodule

// ===== verilog/lic_pkg.sv
// Constants and types shared by the line interface control block
package lic_pkg;
	// ==========================================================
	// Clock and timing
	localparam int SYS_CLK_MHZ = 100;
	localparam int HW_RST_HOLD_NS = 200;
	// Least hold time rounds up to whole cycles
	localparam int HW_RST_CYC = (HW_RST_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int T1_RATE_HZ = 1544000;
	localparam int E1_RATE_HZ = 2048000;
	localparam int QUAL_SEC = 5;
	localparam int QUAL_BITS_T1_DEF = T1_RATE_HZ * QUAL_SEC;
	localparam int QUAL_BITS_E1_DEF = E1_RATE_HZ * QUAL_SEC;
	localparam int TOGGLE_WIN_DEF = 256;
	// ==========================================================
	// Signal absent detector
	localparam int LOS_ZERO_RUN = 175;
	localparam int LOS_WIN_BITS = 175;
	localparam int LOS_MAX_ZRUN = 100;
	localparam int LOS_DENS_DIV = 8;
	localparam int LOS_ONES_MIN = (LOS_WIN_BITS + LOS_DENS_DIV - 1) / LOS_DENS_DIV;
	// ==========================================================
	// Gain code frame
	localparam logic [2:0] GAIN_FRAME_LAST = 3'h4;
	localparam logic [1:0] GAIN_0DB = 2'h0;
	localparam logic [2:0] GAIN_0DB_LEN = 3'h4;
	// ==========================================================
	// Register map and fields
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_GAIN = 8'h08;
	localparam logic [7:0] ADR_SER = 8'h0c;
	localparam int CT_MARKS = 0;
	localparam int CT_NEAR = 1;
	localparam int CT_FAR = 2;
	localparam int CT_DEJITTER_PATH_SEL = 3;
	localparam int CT_LBO = 4;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// ==========================================================
	// Synchroniser lanes
	localparam int SY_MODE = 0, SY_MCLK = 1, SY_OSC = 2, SY_RCLK = 3;
	localparam int SY_RXB = 4, SY_MARKS = 5, SY_NEAR = 6, SY_FAR = 7;
	localparam int SY_DEJITTER_PATH_SEL = 8, SY_LBO = 9, SY_SCLK = 11, SY_SDI = 12;
	localparam int SY_EDGE = 13, SY_UNI = 14, SY_E1 = 15, SY_AIS = 16;
	localparam int SY_GAIN = 17, SY_W = 19;
	// Recovered clock source
	typedef enum logic [1:0] {SRC_LINE, SRC_MCLK, SRC_HOLD, SRC_OSC}
		lic_rclk_src_t;
endpackage

// ===== verilog/lic_top.sv
// Line interface control, diagnostics and status logic
// Functional notes
// R1: mode pin high selects host control
// R2: mode tied to recovered clock enables B8ZS; the code also needs the unipolar input high
// R3: master clock preferred over oscillator
// R4: dejitter enabled by clocked or low oscillator; the code enables a low oscillator only with master clock present
// R5: path select puts dejitter in rx or tx
// R6: all marks select sends continuous ones
// R7: far loopback overrides all marks
// R8: near loopback loops whole datapath
// R9: near loopback plus marks loops at dejitter
// R10: near and far without marks resets
// R11: all three selects enable loop code detection
// R12: far loopback bypasses codecs, retransmits received
// R13: two-bit build-out selects pulse shape
// R14: 175 zeros raise signal absent flag
// R15: density window clears signal absent flag
// R16: loss with rx dejitter: master or hold
// R17: loss without rx dejitter: master or oscillator
// R18: loop-up pattern five seconds enters loopback
// R19: loop-down pattern or loopback select exits
// R20: gain code high 1-4 of five cycles
// R21: alert pulled low on status change; the code drives it only in host mode
// R22: serial input sampled on serial clock rise
// R23: controller holds reset combination 200 ns
// R24: host write of both loops clears registers
// R25: serial output edge follows edge select
// R26: five second timers count bits, restart
`timescale 1ns/1ns
module lic_top
	import lic_pkg::*;
#(
	parameter int QUAL_BITS_T1 = QUAL_BITS_T1_DEF,
	parameter int QUAL_BITS_E1 = QUAL_BITS_E1_DEF,
	parameter int TOGGLE_WIN = TOGGLE_WIN_DEF
)(
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_NRST,
	// Wishbone slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [3:0] I_WB_SEL,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	// Mode and reference pins
	input wire logic I_MODE_SEL,
	input wire logic I_MCLK,
	input wire logic I_OSC_REF_IN,
	input wire logic I_UNIPOLAR,
	input wire logic I_E1_SEL,
	// Hardware control pins
	input wire logic I_SEND_ALL_MARKS_SEL,
	input wire logic I_NEAR_END_LOOPBACK_SEL,
	input wire logic I_FAR_END_LOOPBACK_SEL,
	input wire logic I_DEJITTER_PATH_SEL,
	input wire logic [1:0] I_TX_PULSE_BUILDOUT_SEL,
	// Receive side
	input wire logic I_RCLK,
	input wire logic I_RX_BIT,
	input wire logic [1:0] I_EQ_GAIN,
	input wire logic I_ALL_ONES_ALARM,
	// Serial port
	input wire logic I_SCLK,
	input wire logic I_SERIAL_IN,
	input wire logic I_OUTPUT_EDGE_SEL,
	output logic O_SERIAL_OUT,
	// Configuration outputs
	output logic O_HOST_MODE,
	output logic O_B8ZS_EN,
	output logic O_REF_FROM_MCLK,
	output logic O_DEJITTER_EN,
	output logic O_DEJITTER_IN_RX,
	output logic [1:0] O_TX_PULSE_BUILDOUT,
	// Diagnostic path outputs
	output logic O_TX_ALL_MARKS,
	output logic O_NEAR_LOOP_LINE,
	output logic O_NEAR_LOOP_DEJITTER,
	output logic O_FAR_LOOP,
	output logic O_CODEC_BYPASS,
	output logic O_LOOP_DETECT_EN,
	output logic O_CAL_RESTART,
	// Status outputs
	output logic O_SIGNAL_ABSENT_FLAG,
	output lic_rclk_src_t O_RCLK_SRC,
	output logic O_INBAND_LOOP_STATE,
	output logic O_RX_GAIN_CODE_OUT,
	output logic O_ALERT_N_O,
	output logic O_ALERT_N_OE
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_NRST);

	// ==========================================================
	// Input synchroniser and edge history
	logic [SY_W-1:0] sync1_ff; // First stage, read by sync2 only
	logic [SY_W-1:0] sync2_ff; // Settled pin levels
	logic [SY_W-1:0] prev_ff; // Previous settled levels for edges
	wire [SY_W-1:0] raw_pins = {I_EQ_GAIN, I_ALL_ONES_ALARM, I_E1_SEL,
		I_UNIPOLAR, I_OUTPUT_EDGE_SEL, I_SERIAL_IN, I_SCLK,
		I_TX_PULSE_BUILDOUT_SEL, I_DEJITTER_PATH_SEL,
		I_FAR_END_LOOPBACK_SEL, I_NEAR_END_LOOPBACK_SEL,
		I_SEND_ALL_MARKS_SEL, I_RX_BIT, I_RCLK, I_OSC_REF_IN, I_MCLK,
		I_MODE_SEL};

	// Every pin is asynchronous to the system clock
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			prev_ff <= '0;
		end
		else
		begin
			sync1_ff <= raw_pins;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	wire [SY_W-1:0] pin_edge = sync2_ff ^ prev_ff;
	wire rx_rise = sync2_ff[SY_RCLK] & ~prev_ff[SY_RCLK];
	wire rx_bit = sync2_ff[SY_RXB];
	wire sclk_rise = sync2_ff[SY_SCLK] & ~prev_ff[SY_SCLK];
	wire sclk_fall = ~sync2_ff[SY_SCLK] & prev_ff[SY_SCLK];

	// ==========================================================
	// Activity detectors: mode, master clock, oscillator
	logic [2:0] tog; // Lane seen toggling within the window
	genvar g;
	for (g = 0; g < 3; g++)
	begin : g_act
		logic [15:0] idle_ff; // Cycles since the last edge, saturating
		// A static level is told from a clock by the gap between edges
		always_ff @(posedge I_CLK_SYS or negedge I_NRST)
		begin
			if (!I_NRST)
				idle_ff <= 16'(TOGGLE_WIN);
			else if (pin_edge[g])
				idle_ff <= 16'h0000;
			else if (idle_ff != 16'(TOGGLE_WIN))
				idle_ff <= idle_ff + 16'h0001;
		end
		assign tog[g] = (idle_ff != 16'(TOGGLE_WIN));
	end

	wire mode_tog = tog[SY_MODE];
	wire mclk_pres = tog[SY_MCLK];
	wire host_mode = sync2_ff[SY_MODE] & ~mode_tog; // [R1]
	wire b8zs_en = mode_tog & sync2_ff[SY_UNI]; // [R2]
	// Clocked oscillator, or static low with master clock present
	wire ja_en = tog[SY_OSC] | (mclk_pres & ~sync2_ff[SY_OSC]); // [R4]

	// ==========================================================
	// Register bus and control selection
	logic [5:0] ctrl_ff; // Host control bits
	logic wb_ack_ff; // Single-cycle acknowledge
	logic [31:0] wb_dat_ff; // Registered read data
	logic alert_ff; // Status change latched for the alert pin
	logic [7:0] ser_in_ff; // Bits shifted in from the serial input
	logic los_ff; // Signal absent flag
	logic inband_ff; // In-band network loopback state
	wire wb_req = I_WB_CYC & I_WB_STB & ~wb_ack_ff;
	wire ctrl_wr = wb_req & I_WB_WE & I_WB_SEL[0] & (I_WB_ADR == ADR_CTRL);
	wire stat_rd = wb_req & ~I_WB_WE & (I_WB_ADR == ADR_STAT);
	wire host_rst_wr = ctrl_wr & I_WB_DAT[CT_NEAR] & I_WB_DAT[CT_FAR];
	wire [5:0] ctl = host_mode ? ctrl_ff : sync2_ff[SY_LBO+1:SY_MARKS];
	wire sel_m = ctl[CT_MARKS];
	wire sel_n = ctl[CT_NEAR];
	wire sel_f = ctl[CT_FAR];
	wire three = sel_m & sel_n & sel_f;
	logic [7:0] rst_cnt_ff; // Cycles the reset combination is held
	wire hw_combo = ~host_mode & ~sel_m & sel_n & sel_f;
	wire hw_fire = hw_combo & (rst_cnt_ff == 8'(HW_RST_CYC - 1));
	wire dev_rst = hw_fire | host_rst_wr;

	// Host writes; both loop bits at once clear to zero instead
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			ctrl_ff <= CTRL_RST;
		else if (dev_rst)
			ctrl_ff <= CTRL_RST; // [R24]
		else if (ctrl_wr)
			ctrl_ff <= I_WB_DAT[5:0];
	end

	// Hold counter; the controller keeps the combination long enough
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			rst_cnt_ff <= 8'h00;
		else if (!hw_combo)
			rst_cnt_ff <= 8'h00;
		else if (rst_cnt_ff != 8'(HW_RST_CYC)) // [R23]
			rst_cnt_ff <= rst_cnt_ff + 8'h01;
	end

	// Acknowledge and read data; unmapped reads return zero
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_ff <= wb_req;
			case (I_WB_ADR)
				ADR_CTRL: wb_dat_ff <= {26'h0, ctrl_ff};
				ADR_STAT: wb_dat_ff <= {24'h0, alert_ff, b8zs_en, mclk_pres,
					ja_en, host_mode, sync2_ff[SY_AIS], inband_ff, los_ff};
				ADR_GAIN: wb_dat_ff <= {30'h0, sync2_ff[SY_GAIN+1:SY_GAIN]};
				ADR_SER: wb_dat_ff <= {24'h0, ser_in_ff};
				default: wb_dat_ff <= 32'h0000_0000;
			endcase
		end
	end
	a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack held past one cycle");
	a_host_clear: assert property (host_rst_wr |=> // [R24]
		(ctrl_ff == CTRL_RST) && O_CAL_RESTART)
		else $error("host reset did not clear control");

	// ==========================================================
	// Signal absent detector, counted on recovered clock rises
	logic [7:0] zrun_ff; // Consecutive zeros, saturating
	logic win_act_ff; // Density window running
	logic [7:0] wcnt_ff; // Bits seen in the window
	logic [7:0] wones_ff; // Ones seen in the window
	logic [7:0] wzrun_ff; // Zero run inside the window
	wire los_hit = ~rx_bit & (zrun_ff == 8'(LOS_ZERO_RUN - 1));
	wire win_abort = ~rx_bit & (wzrun_ff == 8'(LOS_MAX_ZRUN - 1));
	wire win_last = win_act_ff & (wcnt_ff == 8'(LOS_WIN_BITS - 1));
	wire win_ok = win_last & ~win_abort &
		((wones_ff + {7'h0, rx_bit}) >= 8'(LOS_ONES_MIN));

	// Zero run counter
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			zrun_ff <= 8'h00;
		else if (rx_rise)
		begin
			if (rx_bit)
				zrun_ff <= 8'h00;
			else if (zrun_ff != 8'(LOS_ZERO_RUN))
				zrun_ff <= zrun_ff + 8'h01;
		end
	end

	// Flag: a fresh zero run beats a passing window
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			los_ff <= 1'b0;
		else if (rx_rise && los_hit)
			los_ff <= 1'b1; // [R14]
		else if (rx_rise && win_ok)
			los_ff <= 1'b0; // [R15]
	end

	// Recovery window opens on a one while the flag is up
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			win_act_ff <= 1'b0;
			wcnt_ff <= 8'h00;
			wones_ff <= 8'h00;
			wzrun_ff <= 8'h00;
		end
		else if (rx_rise)
		begin
			if (win_act_ff)
			begin
				wcnt_ff <= wcnt_ff + 8'h01;
				wones_ff <= wones_ff + {7'h0, rx_bit};
				wzrun_ff <= rx_bit ? 8'h00 : wzrun_ff + 8'h01;
				// Too long a zero run, or window complete
				if (win_abort || win_last)
					win_act_ff <= 1'b0; // [R15]
			end
			else if (los_ff && rx_bit)
			begin
				win_act_ff <= 1'b1;
				wcnt_ff <= 8'h01;
				wones_ff <= 8'h01;
				wzrun_ff <= 8'h00;
			end
		end
	end
	a_los_set: assert property (rx_rise && los_hit |=> los_ff) // [R14]
		else $error("signal absent not raised after zero run");
	a_los_clear: assert property ($fell(los_ff) |-> // [R15]
		$past(win_act_ff) && ($past(wcnt_ff) == 8'(LOS_WIN_BITS - 1)))
		else $error("signal absent cleared outside window end");

	// ==========================================================
	// In-band loop code qualification
	logic [5:0] hist_ff; // Last received bits
	logic [23:0] up_cnt_ff; // Bits of unbroken loop-up pattern
	logic [23:0] dn_cnt_ff; // Bits of unbroken loop-down pattern
	wire [5:0] nh = {hist_ff[4:0], rx_bit};
	wire up_match = (nh[5] == nh[0]) & ($countones(nh[4:0]) == 1);
	wire dn_match = (nh[3] == nh[0]) & ($countones(nh[2:0]) == 1);
	wire [23:0] qual = sync2_ff[SY_E1] ? 24'(QUAL_BITS_E1 - 1) :
		24'(QUAL_BITS_T1 - 1);
	wire up_fire = rx_rise & three & up_match & (up_cnt_ff == qual);
	wire dn_fire = rx_rise & three & dn_match & (dn_cnt_ff == qual);
	wire loop_sel = (sel_n | sel_f) & ~three;

	// Timers count line bits; any broken period restarts them
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			hist_ff <= 6'h00;
			up_cnt_ff <= 24'h000000;
			dn_cnt_ff <= 24'h000000;
		end
		else if (rx_rise)
		begin
			hist_ff <= nh;
			if (!three || !up_match) // [R11] [R26]
				up_cnt_ff <= 24'h000000;
			else if (up_cnt_ff != qual)
				up_cnt_ff <= up_cnt_ff + 24'h000001;
			if (!three || !dn_match) // [R26]
				dn_cnt_ff <= 24'h000000;
			else if (dn_cnt_ff != qual)
				dn_cnt_ff <= dn_cnt_ff + 24'h000001;
		end
	end

	// Loopback state: reset and exits take priority
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			inband_ff <= 1'b0;
		else if (dev_rst || dn_fire || loop_sel)
			inband_ff <= 1'b0; // [R19] [R10]
		else if (up_fire)
			inband_ff <= 1'b1; // [R18]
	end
	a_inband_set: assert property (up_fire && !dev_rst |=> inband_ff) // [R18]
		else $error("loop-up qualified but loopback not entered");
	a_inband_exit: assert property (loop_sel |=> !inband_ff) // [R19]
		else $error("loopback select did not end network loopback");

	// ==========================================================
	// Gain code framing on recovered clock rises
	logic [2:0] phase_ff; // Position in the five-cycle frame
	logic gain_ff; // Encoded gain level
	wire [1:0] eq = sync2_ff[SY_GAIN+1:SY_GAIN];
	wire [2:0] glen = (eq == GAIN_0DB) ? GAIN_0DB_LEN : {1'b0, eq};
	wire [2:0] nxt_phase = (phase_ff == GAIN_FRAME_LAST) ? 3'h0 :
		phase_ff + 3'h1;

	// High for the first glen cycles of every frame
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			phase_ff <= 3'h0;
			gain_ff <= 1'b0;
		end
		else if (rx_rise)
		begin
			phase_ff <= nxt_phase;
			gain_ff <= (nxt_phase < glen); // [R20]
		end
	end
	a_gain_frame: assert property (rx_rise |=> // [R20]
		gain_ff == (phase_ff < $past(glen)))
		else $error("gain code out of step with frame");

	// ==========================================================
	// Alert and serial port
	logic [2:0] stat_prev_ff; // Watched status one cycle back
	logic [7:0] ser_out_sh_ff; // Status byte being shifted out
	logic [2:0] ser_cnt_ff; // Bits shifted out of the byte
	wire [2:0] stat_now = {inband_ff, sync2_ff[SY_AIS], los_ff};
	wire stat_chg = |(stat_now ^ stat_prev_ff);
	// Update on the opposite edge so the bit is steady on the chosen one
	wire ser_upd = sync2_ff[SY_EDGE] ? sclk_fall : sclk_rise; // [R25]

	// Sticky change flag: a change in the clearing read still wins
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			stat_prev_ff <= 3'h0;
			alert_ff <= 1'b0;
		end
		else
		begin
			stat_prev_ff <= stat_now;
			if (stat_chg)
				alert_ff <= 1'b1; // [R21]
			else if (stat_rd || dev_rst)
				alert_ff <= 1'b0;
		end
	end
	a_alert_set: assert property (stat_chg |=> alert_ff) // [R21]
		else $error("status change not latched for alert");

	// Serial input bits taken on serial clock rises
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
			ser_in_ff <= 8'h00;
		else if (dev_rst)
			ser_in_ff <= 8'h00;
		else if (sclk_rise)
			ser_in_ff <= {ser_in_ff[6:0], sync2_ff[SY_SDI]}; // [R22]
	end
	a_ser_sample: assert property (sclk_rise && !dev_rst |=> // [R22]
		ser_in_ff[0] == $past(sync2_ff[SY_SDI]))
		else $error("serial input not sampled on rise");

	// Status byte shifted out most significant bit first
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			ser_out_sh_ff <= 8'h00;
			ser_cnt_ff <= 3'h0;
			O_SERIAL_OUT <= 1'b0;
		end
		else if (ser_upd)
		begin
			O_SERIAL_OUT <= ser_out_sh_ff[7]; // [R25]
			ser_cnt_ff <= ser_cnt_ff + 3'h1;
			ser_out_sh_ff <= (ser_cnt_ff == 3'h7) ?
				{5'h00, stat_now} : {ser_out_sh_ff[6:0], 1'b0};
		end
	end

	// ==========================================================
	// Path decode and registered outputs
	wire far_eff = (sel_f & ~sel_n) | inband_ff; // [R12]
	wire ja_rx = ja_en & ctl[CT_DEJITTER_PATH_SEL]; // [R5]
	lic_rclk_src_t nxt_src; // Recovered clock source

	// Clock source during signal loss
	always_comb
	begin
		nxt_src = SRC_LINE;
		if (los_ff && ja_rx)
			nxt_src = mclk_pres ? SRC_MCLK : SRC_HOLD; // [R16]
		else if (los_ff)
			nxt_src = mclk_pres ? SRC_MCLK : SRC_OSC; // [R17]
	end

	// All outputs from flip-flops
	always_ff @(posedge I_CLK_SYS or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			O_HOST_MODE <= 1'b0;
			O_B8ZS_EN <= 1'b0;
			O_REF_FROM_MCLK <= 1'b0;
			O_DEJITTER_EN <= 1'b0;
			O_DEJITTER_IN_RX <= 1'b0;
			O_TX_PULSE_BUILDOUT <= 2'h0;
			O_TX_ALL_MARKS <= 1'b0;
			O_NEAR_LOOP_LINE <= 1'b0;
			O_NEAR_LOOP_DEJITTER <= 1'b0;
			O_FAR_LOOP <= 1'b0;
			O_CODEC_BYPASS <= 1'b0;
			O_LOOP_DETECT_EN <= 1'b0;
			O_CAL_RESTART <= 1'b0;
			O_RCLK_SRC <= SRC_LINE;
			O_ALERT_N_O <= 1'b0;
			O_ALERT_N_OE <= 1'b0;
		end
		else
		begin
			O_HOST_MODE <= host_mode; // [R1]
			O_B8ZS_EN <= b8zs_en; // [R2]
			O_REF_FROM_MCLK <= mclk_pres; // [R3]
			O_DEJITTER_EN <= ja_en; // [R4]
			O_DEJITTER_IN_RX <= ja_rx; // [R5]
			O_TX_PULSE_BUILDOUT <= ctl[CT_LBO+1:CT_LBO]; // [R13]
			O_TX_ALL_MARKS <= sel_m & ~far_eff; // [R6] [R7] [R9]
			O_NEAR_LOOP_LINE <= sel_n & ~sel_f & ~sel_m; // [R8]
			O_NEAR_LOOP_DEJITTER <= sel_n & ~sel_f & sel_m; // [R9]
			O_FAR_LOOP <= far_eff; // [R12]
			O_CODEC_BYPASS <= far_eff; // [R12]
			O_LOOP_DETECT_EN <= three; // [R11]
			O_CAL_RESTART <= dev_rst; // [R10]
			O_RCLK_SRC <= nxt_src;
			O_ALERT_N_O <= 1'b0;
			O_ALERT_N_OE <= alert_ff & host_mode; // [R21]
		end
	end
	assign O_WB_ACK = wb_ack_ff;
	assign O_WB_DAT = wb_dat_ff;
	assign O_SIGNAL_ABSENT_FLAG = los_ff;
	assign O_INBAND_LOOP_STATE = inband_ff;
	assign O_RX_GAIN_CODE_OUT = gain_ff;

	a_host_sel: assert property (host_mode |=> O_HOST_MODE) // [R1]
		else $error("host mode not selected");
	a_marks_prec: assert property (O_FAR_LOOP |-> !O_TX_ALL_MARKS) // [R7]
		else $error("all marks sent during far loopback");
	a_hw_reset: assert property (hw_fire |=> // [R10]
		O_CAL_RESTART && !inband_ff)
		else $error("reset combination did not reset");
	a_src_osc: assert property (los_ff && !ja_rx && !mclk_pres |=> // [R17]
		O_RCLK_SRC == SRC_OSC)
		else $error("clock source not oscillator during loss");
endmodule
